// File: rtl/uss_pkg.sv
// Purpose: shared constants and types of the universal shift/storage register block
// Assumes: AXI4-Lite register access with 32-bit data and byte addressing
// Notes:   mode select codes are {mode_select_high, mode_select_low}

package uss_pkg;

   localparam int          USS_STAGES      = 8;
   localparam int          USS_FIFO_DEPTH  = 4;
   localparam int          USS_AXI_AW      = 8;
   localparam int          USS_AXI_DW      = 32;
   localparam int          USS_CNT_W       = 16;

   // register byte offsets
   localparam logic [7:0]  USS_OFF_CTRL    = 8'h00;
   localparam logic [7:0]  USS_OFF_CMD     = 8'h04;
   localparam logic [7:0]  USS_OFF_STATUS  = 8'h08;
   localparam logic [7:0]  USS_OFF_EDGES   = 8'h0C;
   localparam logic [7:0]  USS_OFF_CMDS    = 8'h10;

   // control fields
   localparam int          USS_CTRL_RUN    = 0;

   // command fields
   localparam int          USS_CMD_MODE_LO = 0;
   localparam int          USS_CMD_RSI     = 2;
   localparam int          USS_CMD_LSI     = 3;
   localparam int          USS_CMD_DATA_LO = 8;

   // status fields
   localparam int          USS_ST_STAGE_LO = 0;
   localparam int          USS_ST_EMPTY    = 8;
   localparam int          USS_ST_FULL     = 9;
   localparam int          USS_ST_FIRST    = 10;
   localparam int          USS_ST_LAST     = 11;
   localparam int          USS_ST_SEL_LO   = 12;
   localparam int          USS_ST_DRIVE    = 14;
   localparam int          USS_ST_CLEAR    = 15;

   localparam logic [1:0]  USS_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  USS_RESP_SLVERR = 2'h2;

   // mode select codes {high, low}
   localparam logic [1:0]  USS_SEL_HOLD    = 2'h0;
   localparam logic [1:0]  USS_SEL_SHR     = 2'h1;
   localparam logic [1:0]  USS_SEL_SHL     = 2'h2;
   localparam logic [1:0]  USS_SEL_LOAD    = 2'h3;

   localparam logic [7:0]  USS_STAGES_RST  = 8'h00;

   typedef enum logic [1:0] {
      uss_op_hold,
      uss_op_shr,
      uss_op_shl,
      uss_op_load
   } uss_op_t;

   typedef struct packed {
      logic       clk;
      logic       sel_hi;
      logic       sel_lo;
      logic       rsi;
      logic       lsi;
      logic       clr_n;
      logic       en_a_n;
      logic       en_b_n;
      logic [7:0] data;
   } uss_pins_t;

   localparam uss_pins_t USS_PINS_IDLE = '{clk: 1'b0, sel_hi: 1'b0, sel_lo: 1'b0,
                                           rsi: 1'b0, lsi: 1'b0, clr_n: 1'b1,
                                           en_a_n: 1'b1, en_b_n: 1'b1, data: 8'h00};

   typedef struct packed {
      logic [7:0] data;
      logic       lsi;
      logic       rsi;
      logic [1:0] sel;
   } uss_cmd_t;

endpackage

// File: rtl/uss_fifo.sv
// Purpose: small command FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   storage is flops; depth need not be a power of two

`timescale 1ns/1ns
`default_nettype none

module uss_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 4
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [CW-1:0]    count_q;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign in_ready  = (count_q != CW'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= next_ptr(rd_ptr_q);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= count_q + CW'(1);
      end else if (pop && !push) begin
         count_q <= count_q - CW'(1);
      end
   end

endmodule

`default_nettype wire

// File: rtl/uss_shift_storage.sv
// Purpose: eight-stage universal shift/storage register with shared parallel pins
// Assumes: all pin inputs are asynchronous to aclk and are synchronised here
// Notes:   software may also queue operations through a command FIFO over AXI4-Lite
//
// How it works
// - eight D-type stages numbered 0 to 7 hold the state
// - master clear low zeroes all stages, overriding selects and clock
// - other state changes happen only on a rising edge of the shift clock or when a queued command is popped
// - selects: 11 load, 01 shift right, 10 shift left, 00 hold
// - shift right: stage 0 takes right serial input, stage n moves to n+1
// - shift left: stage 7 takes left serial input, stage n moves to n-1
// - parallel load: each stage n captures parallel pin n
// - each stage drives its own parallel pin while drivers are enabled
// - either active-low output enable high releases all parallel pins
// - disabled drivers do not affect shift, hold, load or clear
// - both selects high disable parallel drivers regardless of enables
// - stages 0 and 7 appear on dedicated serial outputs for chaining

`timescale 1ns/1ns
`default_nettype none

module uss_shift_storage
   import uss_pkg::*;
#(
   parameter int FIFO_DEPTH = USS_FIFO_DEPTH
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite slave
   input  wire logic [USS_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [USS_AXI_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic      [1:0]            s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [USS_AXI_AW-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic      [USS_AXI_DW-1:0] s_axi_rdata,
   output logic      [1:0]            s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // device pins
   input  wire logic                  shift_clock,
   input  wire logic                  mode_select_low,
   input  wire logic                  mode_select_high,
   input  wire logic                  right_shift_serial_in,
   input  wire logic                  left_shift_serial_in,
   input  wire logic                  master_clear_n,
   input  wire logic                  parallel_drive_enable_a_n,
   input  wire logic                  parallel_drive_enable_b_n,
   input  wire logic [USS_STAGES-1:0] parallel_bidir_pins_i,
   output logic      [USS_STAGES-1:0] parallel_bidir_pins_o,
   output logic      [USS_STAGES-1:0] parallel_bidir_pins_oe,
   output logic                       first_stage_serial_out,
   output logic                       last_stage_serial_out
);

   uss_pins_t             pins_raw;
   uss_pins_t             sync1_q;
   uss_pins_t             sync2_q;
   logic                  clk_prev_q;
   logic                  pin_edge;
   logic                  clearing;
   uss_op_t               pin_op;
   uss_op_t               cmd_op;
   logic [USS_STAGES-1:0] stages_q;
   logic                  drive;

   logic                  run_q;
   logic [USS_CNT_W-1:0]  edge_cnt_q;
   logic [USS_CNT_W-1:0]  cmd_cnt_q;

   uss_cmd_t              cmd_in;
   uss_cmd_t              cmd_head;
   logic                  fifo_in_valid;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  cmd_pop;

   logic                  aw_have_q;
   logic [USS_AXI_AW-1:0] aw_addr_q;
   logic                  w_have_q;
   logic [USS_AXI_DW-1:0] w_data_q;
   logic [3:0]            w_strb_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  wr_pend;
   logic                  wr_is_cmd;
   logic                  wr_go;
   logic                  rvalid_q;
   logic [USS_AXI_DW-1:0] rdata_q;
   logic [1:0]            rresp_q;
   logic [USS_AXI_DW-1:0] rd_word;
   logic                  rd_hit;

   function automatic uss_op_t decode_op(input logic [1:0] sel);
      uss_op_t op;
      op = uss_op_hold;
      unique case (sel)
         USS_SEL_HOLD: op = uss_op_hold;
         USS_SEL_SHR:  op = uss_op_shr;
         USS_SEL_SHL:  op = uss_op_shl;
         USS_SEL_LOAD: op = uss_op_load;
      endcase
      return op;
   endfunction

   // one step of the register; shared by the pin path and the command path
   function automatic logic [USS_STAGES-1:0] next_stages(
      input uss_op_t               op,
      input logic [USS_STAGES-1:0] cur,
      input logic                  rsi,
      input logic                  lsi,
      input logic [USS_STAGES-1:0] par
   );
      logic [USS_STAGES-1:0] nxt;
      nxt = cur;
      unique case (op)
         uss_op_hold: nxt = cur;
         uss_op_shr:  nxt = {cur[USS_STAGES-2:0], rsi};
         uss_op_shl:  nxt = {lsi, cur[USS_STAGES-1:1]};
         uss_op_load: nxt = par;
      endcase
      return nxt;
   endfunction

   function automatic logic is_reg(input logic [USS_AXI_AW-1:0] addr,
                                   input logic [7:0]            off);
      return addr[USS_AXI_AW-1:2] == off[USS_AXI_AW-1:2];
   endfunction

   // pin synchroniser; costs two aclk of latency against the pins
   assign pins_raw = '{clk:    shift_clock,
                       sel_hi: mode_select_high,
                       sel_lo: mode_select_low,
                       rsi:    right_shift_serial_in,
                       lsi:    left_shift_serial_in,
                       clr_n:  master_clear_n,
                       en_a_n: parallel_drive_enable_a_n,
                       en_b_n: parallel_drive_enable_b_n,
                       data:   parallel_bidir_pins_i};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= USS_PINS_IDLE;
         sync2_q <= USS_PINS_IDLE;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   // data and selects travel with the clock, so they line up at the edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= sync2_q.clk;
      end
   end

   assign pin_edge = sync2_q.clk & ~clk_prev_q;
   assign clearing = ~sync2_q.clr_n;
   assign pin_op   = decode_op({sync2_q.sel_hi, sync2_q.sel_lo});
   assign cmd_op   = decode_op(cmd_head.sel);

   // queued commands yield to a pin edge and wait out a clear
   assign cmd_pop  = fifo_out_valid & run_q & ~pin_edge & ~clearing;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stages_q <= USS_STAGES_RST;
      end else if (clearing) begin
         stages_q <= USS_STAGES_RST;
      end else if (pin_edge) begin
         stages_q <= next_stages(pin_op, stages_q, sync2_q.rsi,
                                 sync2_q.lsi, sync2_q.data);
      end else if (cmd_pop) begin
         stages_q <= next_stages(cmd_op, stages_q, cmd_head.rsi,
                                 cmd_head.lsi, cmd_head.data);
      end
   end

   // drivers never feed back into the stage logic, so disabling is harmless
   assign drive = ~sync2_q.en_a_n & ~sync2_q.en_b_n
                & (pin_op != uss_op_load);

   assign parallel_bidir_pins_o  = stages_q;
   assign parallel_bidir_pins_oe = {USS_STAGES{drive}};
   assign first_stage_serial_out = stages_q[0];
   assign last_stage_serial_out  = stages_q[USS_STAGES-1];

   // activity counters; saturate so a long run never wraps silently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_cnt_q <= '0;
      end else if (wr_go && is_reg(aw_addr_q, USS_OFF_EDGES)) begin
         edge_cnt_q <= '0;
      end else if (pin_edge && !clearing && (edge_cnt_q != '1)) begin
         edge_cnt_q <= edge_cnt_q + USS_CNT_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_cnt_q <= '0;
      end else if (wr_go && is_reg(aw_addr_q, USS_OFF_CMDS)) begin
         cmd_cnt_q <= '0;
      end else if (cmd_pop && (cmd_cnt_q != '1)) begin
         cmd_cnt_q <= cmd_cnt_q + USS_CNT_W'(1);
      end
   end

   // command FIFO; when full the write channel stalls until it drains
   assign cmd_in.sel  = s_strb_field(w_strb_q[0],
                                     w_data_q[USS_CMD_MODE_LO +: 2]);
   assign cmd_in.rsi  = w_strb_q[0] & w_data_q[USS_CMD_RSI];
   assign cmd_in.lsi  = w_strb_q[0] & w_data_q[USS_CMD_LSI];
   assign cmd_in.data = w_strb_q[1] ? w_data_q[USS_CMD_DATA_LO +: USS_STAGES]
                                    : USS_STAGES_RST;

   function automatic logic [1:0] s_strb_field(input logic lane, input logic [1:0] v);
      return lane ? v : USS_SEL_HOLD;
   endfunction

   uss_fifo #(
      .WIDTH ($bits(uss_cmd_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_cmd_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (cmd_in),
      .out_valid (fifo_out_valid),
      .out_ready (cmd_pop),
      .out_data  (cmd_head)
   );

   // AXI4-Lite write: address and data are caught independently
   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready  = ~w_have_q;
   assign wr_pend       = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_is_cmd     = is_reg(aw_addr_q, USS_OFF_CMD);
   assign fifo_in_valid = wr_pend & wr_is_cmd;
   assign wr_go         = wr_pend & (~wr_is_cmd | fifo_in_ready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && !aw_have_q) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && !w_have_q) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= USS_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (is_reg(aw_addr_q, USS_OFF_CTRL)   || wr_is_cmd ||
                      is_reg(aw_addr_q, USS_OFF_STATUS) ||
                      is_reg(aw_addr_q, USS_OFF_EDGES)  ||
                      is_reg(aw_addr_q, USS_OFF_CMDS)) ? USS_RESP_OKAY : USS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
      end else if (wr_go && is_reg(aw_addr_q, USS_OFF_CTRL) && w_strb_q[0]) begin
         run_q <= w_data_q[USS_CTRL_RUN];
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // AXI4-Lite read
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (is_reg(s_axi_araddr, USS_OFF_CTRL)) begin
         rd_word[USS_CTRL_RUN] = run_q;
      end else if (is_reg(s_axi_araddr, USS_OFF_CMD)) begin
         rd_word = '0;
      end else if (is_reg(s_axi_araddr, USS_OFF_STATUS)) begin
         rd_word[USS_ST_STAGE_LO +: USS_STAGES] = stages_q;
         rd_word[USS_ST_EMPTY]                  = ~fifo_out_valid;
         rd_word[USS_ST_FULL]                   = ~fifo_in_ready;
         rd_word[USS_ST_FIRST]                  = stages_q[0];
         rd_word[USS_ST_LAST]                   = stages_q[USS_STAGES-1];
         rd_word[USS_ST_SEL_LO +: 2]            = {sync2_q.sel_hi, sync2_q.sel_lo};
         rd_word[USS_ST_DRIVE]                  = drive;
         rd_word[USS_ST_CLEAR]                  = clearing;
      end else if (is_reg(s_axi_araddr, USS_OFF_EDGES)) begin
         rd_word[USS_CNT_W-1:0] = edge_cnt_q;
      end else if (is_reg(s_axi_araddr, USS_OFF_CMDS)) begin
         rd_word[USS_CNT_W-1:0] = cmd_cnt_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign s_axi_arready = ~rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= USS_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_hit ? USS_RESP_OKAY : USS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule

`default_nettype wire

// File: verification/uss_shift_storage_monitor.sv
// Purpose: concurrent checks on the pin side of the shift/storage register
// Assumes: pins stay quiet while queued commands run
// Notes:   latencies follow the two-flop pin synchronisers
`timescale 1ns/1ns
`default_nettype none
module uss_shift_storage_monitor
   import uss_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  shift_clock,
   input wire logic                  mode_select_low,
   input wire logic                  mode_select_high,
   input wire logic                  right_shift_serial_in,
   input wire logic                  left_shift_serial_in,
   input wire logic                  master_clear_n,
   input wire logic                  parallel_drive_enable_a_n,
   input wire logic                  parallel_drive_enable_b_n,
   input wire logic [USS_STAGES-1:0] parallel_bidir_pins_i,
   input wire logic [USS_STAGES-1:0] parallel_bidir_pins_o,
   input wire logic [USS_STAGES-1:0] parallel_bidir_pins_oe,
   input wire logic                  first_stage_serial_out,
   input wire logic                  last_stage_serial_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [1:0] sel;
   assign sel = {mode_select_high, mode_select_low};
   sequence edge_s(logic [1:0] s);
      $rose(shift_clock) && master_clear_n && sel == s;
   endsequence
   shr_step_a: assert property (edge_s(USS_SEL_SHR) |-> ##3
      parallel_bidir_pins_o == {$past(parallel_bidir_pins_o[6:0]), $past(right_shift_serial_in, 3)})
      else $error("shift right result wrong");
   shl_step_a: assert property (edge_s(USS_SEL_SHL) |-> ##3
      parallel_bidir_pins_o == {$past(left_shift_serial_in, 3), $past(parallel_bidir_pins_o[7:1])})
      else $error("shift left result wrong");
   load_step_a: assert property (edge_s(USS_SEL_LOAD) |-> ##3
      parallel_bidir_pins_o == $past(parallel_bidir_pins_i, 3)) else $error("load result wrong");
   hold_step_a: assert property (edge_s(USS_SEL_HOLD) |-> ##3
      $stable(parallel_bidir_pins_o)) else $error("hold changed stages");
   clear_all_a: assert property (!master_clear_n [*4] |->
      parallel_bidir_pins_o == USS_STAGES_RST) else $error("clear left stages set");
   drive_off_a: assert property ((parallel_drive_enable_a_n || parallel_drive_enable_b_n
      || sel == USS_SEL_LOAD) [*3] |-> parallel_bidir_pins_oe == 8'h00)
      else $error("pins driven while disabled");
   drive_on_a: assert property ((!parallel_drive_enable_a_n && !parallel_drive_enable_b_n
      && sel != USS_SEL_LOAD) [*3] |-> parallel_bidir_pins_oe == 8'hFF)
      else $error("pins not driven while enabled");
   serial_out_a: assert property ({first_stage_serial_out, last_stage_serial_out} ==
      {parallel_bidir_pins_o[0], parallel_bidir_pins_o[7]}) else $error("serial outs wrong");
   cover property (edge_s(USS_SEL_LOAD));
   cover property (!master_clear_n [*4]);
   cover property (parallel_bidir_pins_oe == 8'hFF);
endmodule
bind uss_shift_storage uss_shift_storage_monitor u_mon (.aclk, .aresetn, .shift_clock,
   .mode_select_low, .mode_select_high, .right_shift_serial_in, .left_shift_serial_in,
   .master_clear_n, .parallel_drive_enable_a_n, .parallel_drive_enable_b_n,
   .parallel_bidir_pins_i, .parallel_bidir_pins_o, .parallel_bidir_pins_oe,
   .first_stage_serial_out, .last_stage_serial_out);
`default_nettype wire

// File: verification/uss_bus_model.sv
// Purpose: outside logic sharing the parallel pins
// Assumes: no pull resistors on the pins
// Notes:   a released line flips every cycle so a stale level never passes
`timescale 1ns/1ns
`default_nettype none
module uss_bus_model
   import uss_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  drive_en,
   input  wire logic [USS_STAGES-1:0] drive_val,
   input  wire logic [USS_STAGES-1:0] pins_o,
   input  wire logic [USS_STAGES-1:0] pins_oe,
   output logic      [USS_STAGES-1:0] pins_i
);
   logic [USS_STAGES-1:0] last_q = '0;
   always_comb begin
      for (int i = 0; i < USS_STAGES; i++) begin
         pins_i[i] = pins_oe[i] ? pins_o[i] : (drive_en ? drive_val[i] : ~last_q[i]);
      end
   end
   always_ff @(posedge aclk) begin
      last_q <= pins_i;
   end
endmodule
`default_nettype wire

// File: verification/universal_shift_storage_register_8bit_test.sv
// Purpose: self-checking bench for the shift/storage register
// Assumes: pin inputs change only on aclk edges
// Notes:   expectations come from a bench copy of the stage update
`timescale 1ns/1ns
`default_nettype none
module universal_shift_storage_register_8bit_test
   import uss_pkg::*;
;
   localparam int LIMIT = 5000;
   logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
   logic        arvalid = '0, rready = '0, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = '0, araddr = '0, drive_val = '0, exp = '0, pins_i, pins_o, pins_oe;
   logic [31:0] wdata = '0, rdata, rv;
   logic [1:0]  bresp, rresp, resp;
   logic        sclk = '0, msl = '0, msh = '0, rsi = '0, lsi = '0, clr_n = '1;
   logic        en_a_n = '1, en_b_n = '1, drive_en = '0, first, last;
   logic [31:0] cmd [4] = '{32'h8103, 32'h0005, 32'h0001, 32'h000A};
   int          miscompares = 0, tests_run = 0, cycles = 0, edges = 0;
   always #5 aclk = ~aclk;
   uss_shift_storage DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shift_clock(sclk),
      .mode_select_low(msl), .mode_select_high(msh), .right_shift_serial_in(rsi),
      .left_shift_serial_in(lsi), .master_clear_n(clr_n),
      .parallel_drive_enable_a_n(en_a_n), .parallel_drive_enable_b_n(en_b_n),
      .parallel_bidir_pins_i(pins_i), .parallel_bidir_pins_o(pins_o),
      .parallel_bidir_pins_oe(pins_oe), .first_stage_serial_out(first),
      .last_stage_serial_out(last));
   uss_bus_model u_bus (.aclk(aclk), .drive_en(drive_en), .drive_val(drive_val),
      .pins_o(pins_o), .pins_oe(pins_oe), .pins_i(pins_i));
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         test_done();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= d;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= '0;
         if (wvalid && wready) wvalid <= '0;
      end while (!bvalid);
      resp = bresp;
      bready <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= '0;
      end while (!rvalid);
      {rv, resp} = {rdata, rresp};
      rready <= '0;
   endtask
   function automatic logic [7:0] nxt(logic [1:0] s, logic [7:0] c, logic r, logic l,
                                      logic [7:0] p);
      case (s)
         USS_SEL_SHR:  return {c[6:0], r};
         USS_SEL_SHL:  return {l, c[7:1]};
         USS_SEL_LOAD: return p;
         default:      return c;
      endcase
   endfunction
   // status word as the bench expects it from its own pin levels
   function automatic logic [31:0] st(logic full, logic empty);
      return {16'h0, ~clr_n, ~en_a_n & ~en_b_n & ~(msh & msl), msh, msl, exp[7], exp[0],
              full, empty, exp};
   endfunction
   task automatic pin_op(input logic [1:0] s, input logic r, input logic l);
      @(posedge aclk);
      {msh, msl} <= s;
      {rsi, lsi} <= {r, l};
      repeat (4) @(posedge aclk);
      sclk <= '1;
      repeat (4) @(posedge aclk);
      sclk <= '0;
      repeat (4) @(posedge aclk);
      exp = clr_n ? nxt(s, exp, r, l, drive_val) : 8'h00;
      edges += int'(clr_n);
      check(32'(pins_o), 32'(exp));
      check(32'({first, last}), 32'({exp[0], exp[7]}));
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= '1;
      repeat (3) @(posedge aclk);
      rd(USS_OFF_STATUS);
      check(rv, st('0, '1));
      rd(8'h20);
      check(32'(resp), 32'(USS_RESP_SLVERR));
      wr(8'h20, 32'hFF);
      check(32'(resp), 32'(USS_RESP_SLVERR));
      {en_a_n, en_b_n, drive_en} <= 3'h1;
      drive_val <= 8'hA5;
      pin_op(USS_SEL_LOAD, '0, '0);
      check(32'(pins_oe), 32'h0);
      drive_en <= '0;
      pin_op(USS_SEL_SHR, '1, '0);
      pin_op(USS_SEL_SHL, '0, '1);
      pin_op(USS_SEL_HOLD, '1, '1);
      pin_op(USS_SEL_SHR, last, first);
      check(32'(pins_oe), 32'hFF);
      check(32'(pins_i), 32'(exp));
      for (int k = 1; k < 3; k++) begin
         {en_b_n, en_a_n, drive_en} <= {2'(k), 1'h1};
         drive_val <= 8'h3C ^ 8'(k);
         pin_op(USS_SEL_LOAD, '0, '0);
         pin_op(USS_SEL_SHR, '1, '0);
         check(32'(pins_oe), 32'h0);
         rd(USS_OFF_STATUS);
         check(rv, st('0, '1));
      end
      {en_a_n, en_b_n, drive_en, clr_n} <= 4'h0;
      repeat (6) @(posedge aclk);
      check(32'(pins_o), 32'h0);
      pin_op(USS_SEL_SHR, '1, '0);
      rd(USS_OFF_STATUS);
      check(rv, st('0, '1));
      clr_n <= '1;
      repeat (4) @(posedge aclk);
      rd(USS_OFF_EDGES);
      check(rv, 32'(edges));
      // queue fills while stopped, then drains in order
      wr(USS_OFF_CTRL, 32'h0);
      for (int k = 0; k < 4; k++) wr(USS_OFF_CMD, cmd[k]);
      rd(USS_OFF_STATUS);
      check(rv, st('1, '0));
      for (int k = 0; k < 4; k++) exp = nxt(cmd[k][1:0], exp, cmd[k][2], cmd[k][3], cmd[k][15:8]);
      wr(USS_OFF_CTRL, 32'h1);
      check(32'(resp), 32'(USS_RESP_OKAY));
      repeat (8) @(posedge aclk);
      rd(USS_OFF_STATUS);
      check(rv, st('0, '1));
      rd(USS_OFF_CMDS);
      check(32'(resp), 32'(USS_RESP_OKAY));
      check(rv, 32'h4);
      wr(USS_OFF_EDGES, 32'h0);
      rd(USS_OFF_EDGES);
      check(rv, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
